//--- eosr_pkg.sv
// Shared constants and types for the embedded-operation suspend/resume block.
// Assumes a 250 MHz register clock and a serial link with cmd byte then 24-bit address.
package eosr_pkg;
    // Clock and suspend timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int SUSP_LAT_NS   = 1000;
    localparam int SUSP_LAT_CYC  = (SUSP_LAT_NS * 1000) / CLK_PERIOD_PS;

    // APB register offsets
    localparam logic [7:0] OFF_STATUS1 = 8'h00;
    localparam logic [7:0] OFF_STATUS2 = 8'h04;
    localparam logic [7:0] OFF_LAST    = 8'h08;
    localparam logic [7:0] OFF_OPTIME  = 8'h0C;

    // Field positions
    localparam int ST1_BUSY_BIT  = 0;
    localparam int ST1_WEL_BIT   = 1;
    localparam int ST2_PROG_BIT  = 0;
    localparam int ST2_ERASE_BIT = 1;
    localparam int ST2_CHK_BIT   = 4;
    localparam int LAST_ACC_BIT  = 8;
    localparam int LAST_UND_BIT  = 9;

    // Reset values
    localparam logic [15:0] OPTIME_RST = 16'h0400;

    // Address layout: 256 KB sectors, 256 B pages
    localparam int SECT_LSB = 18;
    localparam int PAGE_LSB = 8;

    // Link command codes
    localparam logic [7:0] CMD_READ     = 8'h03;
    localparam logic [7:0] CMD_RDSR1    = 8'h05;
    localparam logic [7:0] CMD_RDSR2    = 8'h07;
    localparam logic [7:0] CMD_WREN     = 8'h06;
    localparam logic [7:0] CMD_WRDI     = 8'h04;
    localparam logic [7:0] CMD_PP       = 8'h02;
    localparam logic [7:0] CMD_SSR_PG   = 8'h42;
    localparam logic [7:0] CMD_SSR_RD   = 8'h4B;
    localparam logic [7:0] CMD_PLB_RD   = 8'hA7;
    localparam logic [7:0] CMD_DYB_RD   = 8'hE0;
    localparam logic [7:0] CMD_SE       = 8'hD8;
    localparam logic [7:0] CMD_CE       = 8'h60;
    localparam logic [7:0] CMD_CHK      = 8'h5B;
    localparam logic [7:0] CMD_SUSP     = 8'h75;
    localparam logic [7:0] CMD_RESUME   = 8'h7A;
    localparam logic [7:0] CMD_WRAR     = 8'h71;
    localparam logic [7:0] CMD_PPB_ERS  = 8'hE4;

    typedef struct packed {
        logic [7:0]  cmd;
        logic [23:0] addr;
    } eosr_txn_t;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_SUSPENDING} eosr_state_t;
    typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SERASE, OP_CERASE, OP_CHECK} eosr_op_t;
endpackage

//--- eosr_core.sv
// Suspend/resume sequencer for embedded program, sector erase and integrity check.
// Assumes a serial link (clock, select, data) from the host, sampled on pclk,
// and an APB master for status and timing registers.
//
// Functional notes
// (R1) Program suspend accepted only while a page program runs.
// (R2) On busy falling, program-suspended flag set if suspended, else clear.
// (R3) Reads served during program suspend; suspended page data undefined.
// (R4) Host must not trust reads inside the suspended page.
// (R5) Erase suspend accepted only during a sector erase.
// (R6) Whole-array erase ignores suspend and runs to completion.
// (R7) On busy falling, erase-suspended flag set if suspended, else clear.
// (R8) During erase suspend, program and read outside the sector accepted.
// (R9) Dynamic protection reads allowed during erase suspend.
// (R10) New erase ignored while any operation is suspended.
// (R11) Host treats reads inside the suspended sector as undefined.
// (R12) Check suspend accepted only while an integrity check runs.
// (R13) On busy falling, check-suspended flag set if suspended, else clear.
// (R14) Reads proceed while an integrity check is suspended.
// (R15) Register writes and persistent protection erase refused in any suspend.
// (R16) Host polls busy until clear before the intermediate operation.
// (R17) Suspended state reached within the suspend latency.
// (R18) Program finished in erase suspend returns to erase suspend, busy low.
// (R19) Reads outside suspended sector or page are served.
// (R20) Program/check suspend refuses write enable/disable, programs, suspend.
// (R21) Program/check suspend accepts status, lock, secure and dynamic reads.
// (R22) Resume sets busy: program first, else erase, else ignored; code resumes a suspended check instead of ignoring.
// (R23) Host leaves the minimum resume-to-suspend gap for progress.
// (R24) Suspend with no eligible operation running changes nothing.
// (R25) Each suspend flag clears when its operation resumes.
`timescale 1ns/1ps
module eosr_core (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        link_clk,
    input  wire logic        link_cs_n,
    input  wire logic        link_si,
    output logic             busy_flag,
    output logic             program_suspended_flag,
    output logic             erase_suspended_flag,
    output logic             integrity_check_suspended_flag,
    output logic             read_undefined
);
    localparam int LAT_MAX = eosr_pkg::SUSP_LAT_CYC;
    // Link synchronisers; first stages feed only second stages
    logic [2:0]  sck_s;
    logic [2:0]  cs_s;
    logic [1:0]  si_s;
    logic [5:0]  bit_cnt;
    logic [7:0]  cmd_sh;
    logic [23:0] addr_sh;
    logic        txn_valid;
    eosr_pkg::eosr_txn_t txn;
    wire sck_rise = sck_s[1] & ~sck_s[2];
    wire cs_rise  = cs_s[1] & ~cs_s[2];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_s <= 3'h0;
            cs_s  <= 3'h7;
            si_s  <= 2'h0;
        end else begin
            sck_s <= {sck_s[1:0], link_clk};
            cs_s  <= {cs_s[1:0], link_cs_n};
            si_s  <= {si_s[0], link_si};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_cnt <= 6'h00;
            cmd_sh  <= 8'h00;
            addr_sh <= 24'h000000;
        end else if (cs_s[1]) begin
            bit_cnt <= 6'h00;
        end else if (sck_rise && bit_cnt != 6'h20) begin
            bit_cnt <= bit_cnt + 6'h01;
            if (bit_cnt < 6'h08) begin
                cmd_sh <= {cmd_sh[6:0], si_s[1]};
            end else begin
                addr_sh <= {addr_sh[22:0], si_s[1]};
            end
        end
    end
    // A frame with fewer than eight bits carries no command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txn_valid <= 1'b0;
            txn       <= '0;
        end else begin
            txn_valid <= cs_rise && bit_cnt >= 6'h08;
            txn       <= '{cmd: cmd_sh, addr: addr_sh};
        end
    end
    // Sequencer state
    eosr_pkg::eosr_state_t state;
    eosr_pkg::eosr_state_t next_state;
    eosr_pkg::eosr_op_t    op_kind;
    logic [15:0] op_left, prog_save, erase_save, chk_save, op_time, susp_cnt, prog_page;
    logic [5:0]  erase_sector;
    logic        wel;
    logic [9:0]  last_txn;
    // Command decode
    wire is_read   = txn.cmd == eosr_pkg::CMD_READ;
    wire is_rdsr   = txn.cmd == eosr_pkg::CMD_RDSR1 || txn.cmd == eosr_pkg::CMD_RDSR2;
    wire is_wren   = txn.cmd == eosr_pkg::CMD_WREN;
    wire is_wrdi   = txn.cmd == eosr_pkg::CMD_WRDI;
    wire is_pp     = txn.cmd == eosr_pkg::CMD_PP;
    wire is_ssr_pg = txn.cmd == eosr_pkg::CMD_SSR_PG;
    wire is_ssr_rd = txn.cmd == eosr_pkg::CMD_SSR_RD;
    wire is_plb    = txn.cmd == eosr_pkg::CMD_PLB_RD;
    wire is_dyb    = txn.cmd == eosr_pkg::CMD_DYB_RD;
    wire is_se     = txn.cmd == eosr_pkg::CMD_SE;
    wire is_ce     = txn.cmd == eosr_pkg::CMD_CE;
    wire is_chk    = txn.cmd == eosr_pkg::CMD_CHK;
    wire is_susp   = txn.cmd == eosr_pkg::CMD_SUSP;
    wire is_resume = txn.cmd == eosr_pkg::CMD_RESUME;
    wire is_wrar   = txn.cmd == eosr_pkg::CMD_WRAR;
    wire is_ppb_er = txn.cmd == eosr_pkg::CMD_PPB_ERS;
    wire is_prog   = is_pp | is_ssr_pg;
    wire is_rd_cls = is_read | is_rdsr | is_ssr_rd | is_plb | is_dyb;
    wire busy       = state != eosr_pkg::ST_IDLE;
    wire ps_or_cs   = program_suspended_flag | integrity_check_suspended_flag;
    wire any_susp   = ps_or_cs | erase_suspended_flag;
    wire in_page    = program_suspended_flag
                      && txn.addr[23:eosr_pkg::PAGE_LSB] == prog_page;
    wire in_sector  = erase_suspended_flag
                      && txn.addr[23:eosr_pkg::SECT_LSB] == erase_sector;
    // Suspend only takes a running program, sector erase or check
    wire susp_ok = state == eosr_pkg::ST_RUN                       // [R1] [R5] [R12]
                   && (op_kind == eosr_pkg::OP_PROG || op_kind == eosr_pkg::OP_SERASE
                       || op_kind == eosr_pkg::OP_CHECK);          // [R6] [R24]
    // Gate per suspend mode
    wire ok_ps = is_rd_cls;                                        // [R3] [R14] [R20] [R21]
    wire ok_es = is_rd_cls | is_wren | is_wrdi                     // [R9] [R19]
                 | (is_prog & ~in_sector);                         // [R8] [R10] [R15]
    wire ok_idle = ~is_resume & ~is_susp;
    wire gate_ok = busy ? is_rdsr
                 : ps_or_cs ? ok_ps
                 : erase_suspended_flag ? ok_es
                 : ok_idle;
    wire need_wel = is_prog | is_se | is_ce | is_wrar | is_ppb_er;
    wire accept   = txn_valid && gate_ok && (~need_wel | wel);
    wire start_prog = accept & is_prog;
    wire start_se   = accept & is_se;
    wire start_ce   = accept & is_ce;
    wire start_chk  = accept & is_chk;
    wire do_susp    = txn_valid & is_susp & susp_ok;
    wire do_resume  = txn_valid & is_resume & ~busy & any_susp;
    wire res_prog   = do_resume & program_suspended_flag;          // [R22]
    wire res_erase  = do_resume & ~program_suspended_flag & erase_suspended_flag;
    wire res_chk    = do_resume & ~program_suspended_flag & ~erase_suspended_flag;
    wire op_done    = busy && op_left == 16'h0001;
    wire susp_done  = state == eosr_pkg::ST_SUSPENDING && susp_cnt == 16'h0001 && !op_done;
    wire [15:0] op_len = (op_time == 16'h0000) ? 16'h0001 : op_time;
    wire start_any  = start_prog | start_se | start_ce | start_chk;
    always_comb begin
        next_state = state;
        case (state)
            eosr_pkg::ST_IDLE: begin
                if (start_any || do_resume) begin
                    next_state = eosr_pkg::ST_RUN;
                end
            end
            eosr_pkg::ST_RUN: begin
                if (op_done) begin
                    next_state = eosr_pkg::ST_IDLE;
                end else if (do_susp) begin
                    next_state = eosr_pkg::ST_SUSPENDING;
                end
            end
            eosr_pkg::ST_SUSPENDING: begin
                if (op_done || susp_done) begin
                    next_state = eosr_pkg::ST_IDLE;                // [R17]
                end
            end
            default: next_state = eosr_pkg::ST_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state     <= eosr_pkg::ST_IDLE;
            busy_flag <= 1'b0;
        end else begin
            state     <= next_state;
            busy_flag <= next_state != eosr_pkg::ST_IDLE;         // [R18] [R22]
        end
    end
    // Operation kind and remaining work
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_kind <= eosr_pkg::OP_NONE;
            op_left <= 16'h0000;
        end else if (start_any) begin
            op_kind <= start_prog ? eosr_pkg::OP_PROG : start_se ? eosr_pkg::OP_SERASE
                     : start_ce ? eosr_pkg::OP_CERASE : eosr_pkg::OP_CHECK;
            op_left <= op_len;
        end else if (do_resume) begin
            op_kind <= res_prog ? eosr_pkg::OP_PROG
                     : res_erase ? eosr_pkg::OP_SERASE : eosr_pkg::OP_CHECK;
            op_left <= res_prog ? prog_save : res_erase ? erase_save : chk_save;
        end else if (op_done || susp_done) begin
            op_kind <= eosr_pkg::OP_NONE;
            op_left <= 16'h0000;
        end else if (busy) begin
            op_left <= op_left - 16'h0001;
        end
    end
    // Suspend latency counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            susp_cnt <= 16'h0000;
        end else if (do_susp) begin
            susp_cnt <= 16'(eosr_pkg::SUSP_LAT_CYC);               // [R17]
        end else if (susp_cnt != 16'h0000) begin
            susp_cnt <= susp_cnt - 16'h0001;
        end
    end
    // Saved progress of suspended operations
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_save  <= 16'h0000;
            erase_save <= 16'h0000;
            chk_save   <= 16'h0000;
        end else if (susp_done) begin
            if (op_kind == eosr_pkg::OP_PROG) prog_save <= op_left - 16'h0001;
            if (op_kind == eosr_pkg::OP_SERASE) erase_save <= op_left - 16'h0001;
            if (op_kind == eosr_pkg::OP_CHECK) chk_save <= op_left - 16'h0001;
        end
    end
    // Suspend flags: a flag is only ever set by a finished suspend
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_suspended_flag         <= 1'b0;
            erase_suspended_flag           <= 1'b0;
            integrity_check_suspended_flag <= 1'b0;
        end else begin
            if (susp_done && op_kind == eosr_pkg::OP_PROG) begin
                program_suspended_flag <= 1'b1;                    // [R2]
            end else if (res_prog) begin
                program_suspended_flag <= 1'b0;                    // [R25]
            end
            if (susp_done && op_kind == eosr_pkg::OP_SERASE) begin
                erase_suspended_flag <= 1'b1;                      // [R7]
            end else if (res_erase) begin
                erase_suspended_flag <= 1'b0;                      // [R25]
            end
            if (susp_done && op_kind == eosr_pkg::OP_CHECK) begin
                integrity_check_suspended_flag <= 1'b1;            // [R13]
            end else if (res_chk) begin
                integrity_check_suspended_flag <= 1'b0;            // [R25]
            end
        end
    end
    // Suspended locations, write enable latch, last transaction record
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prog_page    <= 16'h0000;
            erase_sector <= 6'h00;
        end else begin
            if (start_prog) prog_page <= txn.addr[23:eosr_pkg::PAGE_LSB];
            if (start_se) erase_sector <= txn.addr[23:eosr_pkg::SECT_LSB];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wel <= 1'b0;
        end else if (accept && is_wren) begin
            wel <= 1'b1;
        end else if ((accept && (is_wrdi || need_wel)) || op_done) begin
            wel <= 1'b0;
        end
    end
    // Reads inside a suspended page or sector are served but flagged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_txn       <= 10'h000;
            read_undefined <= 1'b0;
        end else if (txn_valid) begin
            last_txn       <= {(accept & is_read & (in_page | in_sector)), accept, txn.cmd};
            read_undefined <= accept & is_read & (in_page | in_sector);   // [R3] [R19]
        end
    end
    // APB slave: one wait state, outputs registered
    wire apb_acc  = psel & penable & ~pready;
    wire hit_st1  = paddr == eosr_pkg::OFF_STATUS1;
    wire hit_st2  = paddr == eosr_pkg::OFF_STATUS2;
    wire hit_last = paddr == eosr_pkg::OFF_LAST;
    wire hit_opt  = paddr == eosr_pkg::OFF_OPTIME;
    wire mapped   = hit_st1 | hit_st2 | hit_last | hit_opt;
    wire [31:0] st1_val = 32'h00000000
                        | (32'(busy_flag) << eosr_pkg::ST1_BUSY_BIT)
                        | (32'(wel) << eosr_pkg::ST1_WEL_BIT);
    wire [31:0] st2_val = 32'h00000000
                        | (32'(program_suspended_flag) << eosr_pkg::ST2_PROG_BIT)
                        | (32'(erase_suspended_flag) << eosr_pkg::ST2_ERASE_BIT)
                        | (32'(integrity_check_suspended_flag) << eosr_pkg::ST2_CHK_BIT);
    wire [31:0] rd_val  = hit_st1 ? st1_val : hit_st2 ? st2_val
                        : hit_last ? {22'h000000, last_txn}
                        : hit_opt ? {16'h0000, op_time} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc & ~mapped;
            prdata  <= (apb_acc && !pwrite) ? rd_val : 32'h00000000;
        end
    end
    // Timing only changes newly started work, never resumed work or the running count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_time <= eosr_pkg::OPTIME_RST;
        end else if (psel && penable && pready && pwrite && hit_opt) begin
            op_time <= pwdata[15:0];
        end
    end
    // Checks
    a_prog_susp_flag: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
        susp_done && op_kind == eosr_pkg::OP_PROG |=> program_suspended_flag && !busy_flag)
        else $error("program suspend did not set its flag with busy low");
    a_chip_no_susp: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
        txn_valid && is_susp && op_kind == eosr_pkg::OP_CERASE
        |=> state != eosr_pkg::ST_SUSPENDING)
        else $error("chip erase entered suspend");
    a_erase_nested: assert property (@(posedge pclk) disable iff (!presetn) // [R10]
        txn_valid && (is_se || is_ce) && any_susp
        |=> op_kind != eosr_pkg::OP_SERASE && op_kind != eosr_pkg::OP_CERASE)
        else $error("erase started during suspend");
    a_prot_write: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        txn_valid && (is_wrar || is_ppb_er) && any_susp |=> !last_txn[eosr_pkg::LAST_ACC_BIT])
        else $error("protection change accepted during suspend");
    a_susp_latency: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        do_susp |=> ##[0:LAT_MAX] !busy_flag)
        else $error("suspend not reached within latency");
    a_resume_order: assert property (@(posedge pclk) disable iff (!presetn) // [R22]
        res_prog |=> busy_flag && !program_suspended_flag
                     && erase_suspended_flag == $past(erase_suspended_flag))
        else $error("resume did not restart program first");
    a_susp_ignored: assert property (@(posedge pclk) disable iff (!presetn) // [R24]
        txn_valid && is_susp && !busy |=> !busy_flag ##1 $stable(program_suspended_flag)
                                       && $stable(erase_suspended_flag))
        else $error("idle suspend changed state");
    a_ps_refuse: assert property (@(posedge pclk) disable iff (!presetn) // [R20]
        txn_valid && ps_or_cs && !busy && (is_wren || is_wrdi || is_prog)
        |=> !last_txn[eosr_pkg::LAST_ACC_BIT] && !wel == !$past(wel))
        else $error("refused command accepted in program or check suspend");
    a_ps_reads: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
        txn_valid && ps_or_cs && !busy && (is_rdsr || is_plb || is_ssr_rd || is_dyb)
        |=> last_txn[eosr_pkg::LAST_ACC_BIT])
        else $error("allowed read refused in suspend");
    a_back_to_erase: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
        op_done && op_kind == eosr_pkg::OP_PROG && erase_suspended_flag
        |=> erase_suspended_flag && !busy_flag)
        else $error("program in erase suspend did not return to erase suspend");
endmodule

//--- eosr_host.sv
// Link host model: sends command frames, command then address, MSB first.
// Assumes the bench calls send from one process and never overlaps frames.
`timescale 1ns/1ps
module eosr_host (
    output logic link_clk,
    output logic link_cs_n,
    output logic link_si
);
    initial begin
        link_clk  = 1'b0;
        link_cs_n = 1'b1;
        link_si   = 1'b0;
    end

    // Link clock stands still outside frames
    task automatic send(input logic [7:0] c, input logic [23:0] a, input int nb);
        logic [31:0] w;
        w = {c, a};
        link_cs_n = 1'b0;
        for (int i = 0; i < nb; i++) begin
            link_si = w[31-i];
            #31.25 link_clk = 1'b1;
            #62.5 link_clk = 1'b0;
            #31.25;
        end
        link_si   = ~link_si;   // No stale bit after release
        link_cs_n = 1'b1;
        #40;                    // Well over 3 pclk of deselect
    endtask
endmodule

//--- embedded_op_suspend_resume_bench.sv
// Bench for the suspend/resume sequencer: APB master plus link host model.
// Assumes flags are stable a dozen pclk after a frame ends.
`timescale 1ns/1ps
module embedded_op_suspend_resume_bench;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        pready, pslverr, link_clk, link_cs_n, link_si, e;
    logic        busy, prs, ers, cks, rd_und;
    int          miscompares, n_checks, n;
    logic [8:0]  rows [14] = '{{1'b1, 8'h03}, {1'b1, 8'h05}, {1'b1, 8'h07}, {1'b1, 8'hA7},
        {1'b1, 8'h4B}, {1'b1, 8'hE0}, {1'b0, 8'h06}, {1'b0, 8'h04}, {1'b0, 8'h02},
        {1'b0, 8'h42}, {1'b0, 8'h75}, {1'b0, 8'h71}, {1'b0, 8'hE4}, {1'b0, 8'hD8}};

    eosr_core u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_clk(link_clk), .link_cs_n(link_cs_n),
        .link_si(link_si), .busy_flag(busy), .program_suspended_flag(prs),
        .erase_suspended_flag(ers), .integrity_check_suspended_flag(cks),
        .read_undefined(rd_und));
    eosr_host u_host (.link_clk(link_clk), .link_cs_n(link_cs_n), .link_si(link_si));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] %0t got %h exp %h", $time, g, x);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            miscompares++;
            end_of_test();
        end
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Address-carrying commands get full 32-bit frames
    task automatic frame(input logic [7:0] c, input logic [23:0] a);
        u_host.send(c, a, (c inside {8'h03, 8'h02, 8'h42, 8'h4B, 8'hE0, 8'hD8}) ? 32 : 8);
        repeat (12) @(posedge pclk);
    endtask

    task automatic fl(input logic [3:0] x);
        chk({28'h0, busy, prs, ers, cks}, {28'h0, x});
    endtask

    task automatic acc(input logic [7:0] c, input logic [23:0] a, input logic x);
        frame(c, a);
        apb(1'b0, 8'h08, 32'h0);
        chk({23'h0, q[8:0]}, {23'h0, x, c});
    endtask

    // Poll busy until it drops, bounded; n holds the cycles taken
    task automatic wait_idle();
        n = 0;
        while (busy !== 1'b0 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20000) begin
            miscompares++;
            end_of_test();
        end
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, presetn} = '0;
        miscompares = 0;
        n_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        fl(4'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h0000_0400);
        apb(1'b0, 8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        apb(1'b1, 8'h0C, 32'h0000_0800);
        frame(8'h06, 24'h0);
        frame(8'h02, 24'h000100);
        fl(4'h8);
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0000_0001);
        frame(8'h75, 24'h0);
        wait_idle();
        chk({31'h0, n < 260}, 32'h1);
        fl(4'hC ^ 4'h8);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0000_0001);
        for (int i = 0; i < 14; i++) begin
            acc(rows[i][7:0], 24'h040000, rows[i][8]);
        end
        fl(4'h4);
        frame(8'h03, 24'h000120);
        chk({31'h0, rd_und}, 32'h1);
        frame(8'h03, 24'h080000);
        chk({31'h0, rd_und}, 32'h0);
        frame(8'h7A, 24'h0);
        fl(4'h8);
        wait_idle();
        fl(4'h0);
        acc(8'h75, 24'h0, 1'b0);
        fl(4'h0);
        frame(8'h06, 24'h0);
        frame(8'hD8, 24'h040000);
        frame(8'h75, 24'h0);
        wait_idle();
        fl(4'h2);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0000_0002);
        acc(8'hE0, 24'h040000, 1'b1);
        acc(8'hE4, 24'h0, 1'b0);
        acc(8'hD8, 24'h080000, 1'b0);
        frame(8'h06, 24'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk(q, 32'h0000_0002);
        acc(8'h02, 24'h080000, 1'b1);
        fl(4'hA);
        wait_idle();
        fl(4'h2);
        frame(8'h03, 24'h040010);
        chk({31'h0, rd_und}, 32'h1);
        frame(8'h7A, 24'h0);
        fl(4'h8);
        wait_idle();
        frame(8'h06, 24'h0);
        frame(8'h60, 24'h0);
        frame(8'h75, 24'h0);
        repeat (400) @(posedge pclk);
        fl(4'h8);
        wait_idle();
        frame(8'h5B, 24'h0);
        frame(8'h75, 24'h0);
        wait_idle();
        fl(4'h1);
        apb(1'b0, 8'h04, 32'h0);
        chk(q, 32'h0000_0010);
        acc(8'h03, 24'h080000, 1'b1);
        frame(8'h7A, 24'h0);
        fl(4'h8);
        wait_idle();
        fl(4'h0);
        // Reset in mid-program must clear busy and restore the op timing
        frame(8'h06, 24'h0);
        frame(8'h02, 24'h000200);
        fl(4'h8);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        fl(4'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        fl(4'h0);
        apb(1'b0, 8'h0C, 32'h0);
        chk(q, 32'h0000_0400);
        end_of_test();
    end
endmodule
